/* verilog/rgc_mac_if_ctrl.sv */
// Function
// R1 - Three-bit queue threshold, reset value three
// R2 - Interface enable resets from pin two
// R3 - Transmit inversion reverses four data lines
// R4 - Receive inversion reverses lines toward MAC
// R5 - Mask bit ignores MAC transmit error
// R6 - Overflow flag, read only, zero after reset
// R7 - Underflow flag, read only, zero after reset
// R8 - Receive clock aligned, or quarter period late
// R9 - Receive shift resets high on pins 11
// R10 - Transmit shift samples data with skew
// R11 - Transmit shift resets high on 101, 110
// R12 - Wake bit one shows error on control
// R13 - Wake bit zero drives zero data
// R14 - Software never writes wake field 00
// R15 - Serial enable resets high on 000
// R16 - Serial timer codes select four durations
// R17 - Write when full, read when empty
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rgc_mac_if_ctrl import rgc_pkg::*; #(
	parameter int AN_1P6MS_CYC_P = AN_1P6MS_CYC,
	parameter int AN_800US_CYC_P = AN_800US_CYC,
	parameter int AN_11MS_CYC_P = AN_11MS_CYC
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [11:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// Configuration pins
	input wire logic [2:0] config_pins_i,
	// MAC transmit side
	input wire logic mac_tx_clk_i,
	input wire rgc_nib_t mac_tx_i,
	// MAC receive side
	output rgc_rgrx_t mac_rx_o,
	// Core side
	output rgc_nib_t core_tx_o,
	input wire rgc_crx_t core_rx_i,
	// Interrupt
	output logic irq_o
);

	rgc_st_t q;
	rgc_st_t s;
	logic wr_try;
	logic wr_full;
	logic rd_try;
	logic rd_empty;
	logic an_start;
	logic an_done;
	logic [1:0] an_sel;
	logic rx_load;
	logic txc_edge;
	logic cap_now;
	logic mem_we;
	logic mem_re;
	logic [2:0] ev;
	logic [2:0] rx_ph;
	rgc_nib_t wdat;
	rgc_nib_t mem_q;

	function automatic logic [3:0] rev4(input logic [3:0] v);
		return {v[0], v[1], v[2], v[3]};
	endfunction

	function automatic logic [4:0] fill(input logic [4:0] w, input logic [4:0] r);
		return w - r;
	endfunction

	function automatic logic [17:0] an_limit(input logic [1:0] sel);
		logic [17:0] r;
		r = 18'h0;
		unique case (sel)
			2'h0: r = 18'(AN_1P6MS_CYC_P);
			2'h1: r = 18'(AN_2US_CYC);
			2'h2: r = 18'(AN_800US_CYC_P);
			2'h3: r = 18'(AN_11MS_CYC_P);
		endcase
		return r;
	endfunction

	// ==========================================
	// Transmit queue storage
	rgc_nib_mem u_mem (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.wr_en_i(mem_we),
		.wr_addr_i(q.wptr[QADDR_W-1:0]),
		.wr_data_i(wdat),
		.rd_en_i(mem_re),
		.rd_addr_i(q.rptr[QADDR_W-1:0]),
		.rd_data_o(mem_q)
	);

	// ==========================================
	// Next state
	always_comb begin
		s = q;
		wr_try = 1'b0;
		wr_full = 1'b0;
		rd_try = 1'b0;
		rd_empty = 1'b0;
		an_start = 1'b0;
		an_done = 1'b0;
		rx_load = 1'b0;
		txc_edge = 1'b0;
		cap_now = 1'b0;
		mem_we = 1'b0;
		mem_re = 1'b0;
		ev = 3'h0;
		wdat = '0;
		rx_ph = 3'h0;
		// Pin synchronisers
		s.pin_s1 = config_pins_i;
		s.pin_s2 = q.pin_s1;
		s.txc_s1 = mac_tx_clk_i;
		s.txc_s2 = q.txc_s1;
		s.txc_s3 = q.txc_s2;
		s.din_s1 = mac_tx_i;
		s.din_s2 = q.din_s1;
		// R2 strap enable
		s.cfg_load = 1'b0;
		if (q.cfg_load) begin
			s.if_en = q.pin_s2[2];
			// R9 receive skew strap
			s.rx_shift = &q.pin_s2[2:1];
			// R11 transmit skew strap
			s.tx_shift = (q.pin_s2 == STRAP_TX_A) || (q.pin_s2 == STRAP_TX_B);
			// R15 serial enable strap
			s.ser[SER_EN_BIT] = (q.pin_s2 == STRAP_SER);
			an_start = q.ser[SER_AN_BIT];
		end
		// ==========================================
		// Register writes
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				OFS_CTRL: begin
					// R1 threshold field
					s.thr = reg_wdata_i[CTRL_THR_LSB +: 3];
					s.if_en = reg_wdata_i[CTRL_EN_BIT];
					s.inv_tx = reg_wdata_i[CTRL_INVTX_BIT];
					s.inv_rx = reg_wdata_i[CTRL_INVRX_BIT];
					s.err_mask = reg_wdata_i[CTRL_MASK_BIT];
				end
				OFS_SKEW: begin
					s.rx_shift = reg_wdata_i[SKEW_RX_BIT];
					s.tx_shift = reg_wdata_i[SKEW_TX_BIT];
				end
				OFS_WAKE: begin
					s.wake = reg_wdata_i[1:0];
				end
				OFS_SER: begin
					s.ser = reg_wdata_i;
					s.an_run = 1'b0;
					an_start = reg_wdata_i[SER_AN_BIT];
				end
				OFS_IRQ_ST: begin
					s.ist = q.ist & ~reg_wdata_i[2:0];
				end
				OFS_IRQ_MSK: begin
					s.imsk = reg_wdata_i[2:0];
				end
				default: begin
				end
			endcase
		end
		// ==========================================
		// Register reads
		s.rdata = 16'h0000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_CTRL: begin
					s.rdata[CTRL_THR_LSB +: 3] = q.thr;
					s.rdata[CTRL_EN_BIT] = q.if_en;
					s.rdata[CTRL_INVTX_BIT] = q.inv_tx;
					s.rdata[CTRL_INVRX_BIT] = q.inv_rx;
					s.rdata[CTRL_MASK_BIT] = q.err_mask;
				end
				OFS_FIFO: begin
					// R6 overflow flag readback
					s.rdata[FIFO_OVF_BIT] = q.ovf;
					// R7 underflow flag readback
					s.rdata[FIFO_UDF_BIT] = q.udf;
					s.ovf = 1'b0;
					s.udf = 1'b0;
				end
				OFS_SKEW: begin
					s.rdata[SKEW_RX_BIT] = q.rx_shift;
					s.rdata[SKEW_TX_BIT] = q.tx_shift;
				end
				OFS_WAKE: s.rdata[1:0] = q.wake;
				OFS_SER: s.rdata = q.ser;
				OFS_IRQ_ST: s.rdata[2:0] = q.ist;
				OFS_IRQ_MSK: s.rdata[2:0] = q.imsk;
				default: s.rdata = 16'h0000;
			endcase
		end
		// ==========================================
		// R10 skewed transmit capture
		txc_edge = q.txc_s2 && !q.txc_s3;
		if (txc_edge) begin
			s.cap_pend = 1'b1;
			s.cap_cnt = q.tx_shift ? 2'(SKEW_CYC) : 2'h0;
		end else if (q.cap_pend && q.cap_cnt != 2'h0) begin
			s.cap_cnt = q.cap_cnt - 2'h1;
		end
		cap_now = s.cap_pend && (s.cap_cnt == 2'h0);
		if (cap_now) begin
			s.cap_pend = 1'b0;
			s.frame = q.din_s2.en && q.if_en;
			wr_try = s.frame;
			wdat.en = 1'b1;
			// R5 error mask
			wdat.err = q.din_s2.err && !q.err_mask;
			// R3 transmit line order
			wdat.d = q.inv_tx ? rev4(q.din_s2.d) : q.din_s2.d;
		end
		// R17 overflow on full write
		wr_full = (fill(q.wptr, q.rptr) == QDEPTH);
		if (wr_try) begin
			if (wr_full) begin
				ev[IRQ_OVF_BIT] = 1'b1;
			end else begin
				mem_we = 1'b1;
				s.wptr = q.wptr + 5'h1;
			end
		end
		// ==========================================
		// Queue drain toward the core
		s.tdiv = q.tdiv + 3'h1;
		s.rd_valid = 1'b0;
		if (q.rd_valid) begin
			s.ctx = mem_q;
		end
		rd_empty = (fill(q.wptr, q.rptr) == 5'h00);
		if (q.tdiv == 3'(LINK_CYC - 1)) begin
			rd_try = q.started;
			if (!q.started) begin
				s.ctx = '0;
				// R1 start at threshold
				if (!rd_empty && fill(q.wptr, q.rptr) >= {2'b00, q.thr}) begin
					s.started = 1'b1;
				end
			end else if (!rd_empty) begin
				mem_re = 1'b1;
				s.rd_valid = 1'b1;
				s.rptr = q.rptr + 5'h1;
			end else begin
				s.ctx = '0;
				// R17 underflow on empty read
				if (q.frame) begin
					ev[IRQ_UDF_BIT] = 1'b1;
				end else begin
					s.started = 1'b0;
				end
			end
		end
		// ==========================================
		// Receive path toward the MAC
		s.rdiv = (q.rdiv == 3'(LINK_CYC - 1)) ? 3'h0 : q.rdiv + 3'h1;
		if (q.rdiv == 3'(LINK_CYC - 1)) begin
			rx_load = 1'b1;
			if (!q.if_en) begin
				s.rx.ctl = 1'b0;
				s.rx.d = 4'h0;
			end else if (core_rx_i.lpi_exit) begin
				// R12 wake error signalling
				s.rx.ctl = q.wake[WAKE_ERR_BIT];
				// R13 wake zero data
				s.rx.d = q.wake[WAKE_ZERO_BIT] ? 4'h0 : core_rx_i.ib;
			end else if (core_rx_i.lpi) begin
				s.rx.ctl = 1'b0;
				s.rx.d = core_rx_i.ib;
			end else if (core_rx_i.dv) begin
				s.rx.ctl = 1'b1;
				// R4 receive line order
				s.rx.d = q.inv_rx ? rev4(core_rx_i.d) : core_rx_i.d;
			end else begin
				s.rx.ctl = core_rx_i.err;
				s.rx.d = core_rx_i.ib;
			end
		end
		// R8 receive clock phase
		rx_ph = s.rdiv - (q.rx_shift ? 3'(SKEW_CYC) : 3'h0);
		s.rx.clk = q.if_en && (rx_ph < 3'(LINK_CYC / 2));
		// ==========================================
		// R16 serial negotiation timer
		an_sel = s.ser[SER_TMR_LSB +: 2];
		if (an_start) begin
			s.an_run = 1'b1;
			s.an_cnt = an_limit(an_sel);
		end else if (q.an_run) begin
			if (q.an_cnt == 18'h00001) begin
				an_done = 1'b1;
				s.an_run = 1'b0;
				ev[IRQ_AN_BIT] = 1'b1;
			end else begin
				s.an_cnt = q.an_cnt - 18'h00001;
			end
		end
		// ==========================================
		// Sticky flags and interrupt, set wins
		s.ovf = s.ovf | ev[IRQ_OVF_BIT];
		s.udf = s.udf | ev[IRQ_UDF_BIT];
		s.ist = s.ist | ev;
		s.irq = |(s.ist & s.imsk);
	end

	// ==========================================
	// State register
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.thr <= CTRL_RST[CTRL_THR_LSB +: 3];
			q.if_en <= CTRL_RST[CTRL_EN_BIT];
			q.ser <= SER_RST;
			q.cfg_load <= 1'b1;
			q.pin_s1 <= s.pin_s1;
			q.pin_s2 <= s.pin_s2;
		end else begin
			q <= s;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign mac_rx_o = q.rx;
	assign core_tx_o = q.ctx;
	assign irq_o = q.irq;

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_thr_hold: assert property ( // R1
		(q.tdiv == 3'(LINK_CYC - 1) && !q.started && fill(q.wptr, q.rptr) < {2'b00, q.thr})
		|=> !q.started
	) else $error("queue drain started below threshold");

	a_strap_enable: assert property ( // R2
		q.cfg_load && !reg_wr_i |=> q.if_en == $past(q.pin_s2[2])
	) else $error("enable default does not follow pin two");

	a_tx_order: assert property ( // R3
		mem_we && q.inv_tx |-> wdat.d == rev4(q.din_s2.d)
	) else $error("transmit lines not reversed");

	a_rx_order: assert property ( // R4
		rx_load && q.if_en && core_rx_i.dv && !core_rx_i.lpi && !core_rx_i.lpi_exit
		|=> mac_rx_o.d == ($past(q.inv_rx) ? rev4($past(core_rx_i.d)) : $past(core_rx_i.d))
	) else $error("receive line order wrong");

	a_err_mask: assert property ( // R5
		mem_we && q.err_mask |-> !wdat.err
	) else $error("masked transmit error passed");

	a_ovf_flag: assert property ( // R6
		wr_try && wr_full |=> q.ovf && q.ist[IRQ_OVF_BIT]
	) else $error("overflow not flagged");

	a_udf_flag: assert property ( // R7
		rd_try && rd_empty && q.frame |=> q.udf && q.ist[IRQ_UDF_BIT]
	) else $error("underflow not flagged");

	a_rx_aligned: assert property ( // R8
		rx_load && q.if_en && !q.rx_shift && $stable(q.rx_shift) |=> mac_rx_o.clk
	) else $error("receive clock not aligned with data");

	a_rx_lagged: assert property ( // R8
		rx_load && q.if_en && q.rx_shift ##1 q.if_en && q.rx_shift ##1 q.if_en && q.rx_shift
		|-> $past(!mac_rx_o.clk) && !mac_rx_o.clk ##1 mac_rx_o.clk
	) else $error("receive clock not a quarter period late");

	a_strap_skew: assert property ( // R9
		q.cfg_load && !reg_wr_i |=> q.rx_shift == &$past(q.pin_s2[2:1])
	) else $error("receive skew default wrong");

	a_tx_skew: assert property ( // R10
		txc_edge && q.tx_shift |-> !cap_now ##1 !cap_now ##1 cap_now
	) else $error("skewed capture not two cycles late");

	a_strap_txskew: assert property ( // R11
		q.cfg_load && !reg_wr_i
		|=> q.tx_shift == ($past(q.pin_s2) == STRAP_TX_A || $past(q.pin_s2) == STRAP_TX_B)
	) else $error("transmit skew default wrong");

	a_wake_err: assert property ( // R12
		rx_load && q.if_en && core_rx_i.lpi_exit |=> mac_rx_o.ctl == $past(q.wake[WAKE_ERR_BIT])
	) else $error("wake control signalling wrong");

	a_wake_zero: assert property ( // R13
		rx_load && q.if_en && core_rx_i.lpi_exit && q.wake[WAKE_ZERO_BIT] |=> mac_rx_o.d == 4'h0
	) else $error("wake data not zero");

	a_strap_serial: assert property ( // R15
		q.cfg_load && !reg_wr_i |=> q.ser[SER_EN_BIT] == ($past(q.pin_s2) == STRAP_SER)
	) else $error("serial enable default wrong");

	a_an_short: assert property ( // R16
		an_start && an_sel == 2'h1 |-> ##40 an_done
	) else $error("short timer duration wrong");

	a_ovf_drop: assert property ( // R17
		wr_try && wr_full |=> q.wptr == $past(q.wptr)
	) else $error("write accepted while full");

	a_irq_level: assert property (
		irq_o == |(q.ist & q.imsk)
	) else $error("interrupt level mismatch");

	c_overflow: cover property (wr_try && wr_full);
	c_underflow: cover property (rd_try && rd_empty && q.frame);
	c_wake_exit: cover property (rx_load && q.if_en && core_rx_i.lpi_exit);
	c_an_done: cover property (an_done);

endmodule

`default_nettype wire

/* verilog/rgc_pkg.sv */
package rgc_pkg;

	// ==========================================
	// Register offsets
	localparam logic [11:0] OFS_CTRL = 12'h600;
	localparam logic [11:0] OFS_FIFO = 12'h601;
	localparam logic [11:0] OFS_SKEW = 12'h602;
	localparam logic [11:0] OFS_WAKE = 12'h603;
	localparam logic [11:0] OFS_SER = 12'h608;
	localparam logic [11:0] OFS_IRQ_ST = 12'h610;
	localparam logic [11:0] OFS_IRQ_MSK = 12'h611;

	// ==========================================
	// Field positions
	localparam int CTRL_THR_LSB = 4;
	localparam int CTRL_EN_BIT = 3;
	localparam int CTRL_INVTX_BIT = 2;
	localparam int CTRL_INVRX_BIT = 1;
	localparam int CTRL_MASK_BIT = 0;
	localparam int FIFO_OVF_BIT = 1;
	localparam int FIFO_UDF_BIT = 0;
	localparam int SKEW_RX_BIT = 1;
	localparam int SKEW_TX_BIT = 0;
	localparam int WAKE_ERR_BIT = 1;
	localparam int WAKE_ZERO_BIT = 0;
	localparam int SER_EN_BIT = 9;
	localparam int SER_TMR_LSB = 1;
	localparam int SER_AN_BIT = 0;
	localparam int IRQ_OVF_BIT = 0;
	localparam int IRQ_UDF_BIT = 1;
	localparam int IRQ_AN_BIT = 2;

	// ==========================================
	// Reset values and strap codes
	localparam logic [15:0] CTRL_RST = 16'h0030;
	localparam logic [15:0] SER_RST = 16'h007B;
	localparam logic [2:0] STRAP_TX_A = 3'h5;
	localparam logic [2:0] STRAP_TX_B = 3'h6;
	localparam logic [2:0] STRAP_SER = 3'h0;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_PERIOD_NS = 400;
	localparam int LINK_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SKEW_CYC = (LINK_PERIOD_NS / 4) / CLK_PERIOD_NS;
	localparam int AN_1P6MS_NS = 1600000;
	localparam int AN_2US_NS = 2000;
	localparam int AN_800US_NS = 800000;
	localparam int AN_11MS_NS = 11000000;
	localparam int AN_1P6MS_CYC = AN_1P6MS_NS / CLK_PERIOD_NS;
	localparam int AN_2US_CYC = AN_2US_NS / CLK_PERIOD_NS;
	localparam int AN_800US_CYC = AN_800US_NS / CLK_PERIOD_NS;
	localparam int AN_11MS_CYC = AN_11MS_NS / CLK_PERIOD_NS;

	// ==========================================
	// Queue geometry
	localparam int QADDR_W = 4;
	localparam logic [4:0] QDEPTH = 5'h10;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic err;
		logic en;
		logic [3:0] d;
	} rgc_nib_t;

	typedef struct packed {
		logic clk;
		logic ctl;
		logic [3:0] d;
	} rgc_rgrx_t;

	typedef struct packed {
		logic lpi;
		logic lpi_exit;
		logic dv;
		logic err;
		logic [3:0] d;
		logic [3:0] ib;
	} rgc_crx_t;

	typedef struct packed {
		logic [2:0] thr;
		logic if_en;
		logic inv_tx;
		logic inv_rx;
		logic err_mask;
		logic ovf;
		logic udf;
		logic rx_shift;
		logic tx_shift;
		logic [1:0] wake;
		logic [15:0] ser;
		logic [2:0] ist;
		logic [2:0] imsk;
		logic cfg_load;
		logic [15:0] rdata;
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic txc_s1;
		logic txc_s2;
		logic txc_s3;
		rgc_nib_t din_s1;
		rgc_nib_t din_s2;
		logic cap_pend;
		logic [1:0] cap_cnt;
		logic frame;
		logic [4:0] wptr;
		logic [4:0] rptr;
		logic started;
		logic rd_valid;
		logic [2:0] tdiv;
		rgc_nib_t ctx;
		logic [2:0] rdiv;
		rgc_rgrx_t rx;
		logic [17:0] an_cnt;
		logic an_run;
		logic irq;
	} rgc_st_t;

endpackage

/* verilog/rgc_nib_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module rgc_nib_mem import rgc_pkg::*; (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [QADDR_W-1:0] wr_addr_i,
	input wire rgc_nib_t wr_data_i,
	// Read port
	input wire logic rd_en_i,
	input wire logic [QADDR_W-1:0] rd_addr_i,
	output rgc_nib_t rd_data_o
);

	rgc_nib_t mem_q [0:(1<<QADDR_W)-1];

	// ==========================================
	// Storage with registered read
	always_ff @(posedge mclk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end

endmodule

`default_nettype wire

/* tb/rgc_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rgc_mac_model import rgc_pkg::*; (
	// Transmit pins toward the block
	output logic tx_clk_o,
	output rgc_nib_t tx_o
);
	initial begin
		tx_clk_o = 1'b0;
		tx_o = '0;
	end

	// ==========================================
	// One nibble per link clock period
	// edge-aligned or centred data
	task automatic send(input rgc_nib_t n, input logic al);
		if (al) begin
			tx_o = n;
			tx_clk_o = 1'b1;
			#(LINK_PERIOD_NS / 2) tx_clk_o = 1'b0;
			#(LINK_PERIOD_NS / 2);
		end else begin
			tx_o = n;
			#(LINK_PERIOD_NS / 2) tx_clk_o = 1'b1;
			#(LINK_PERIOD_NS / 2) tx_clk_o = 1'b0;
		end
	endtask

	// ==========================================
	// Frame end: one period with enable low, then the clock stands still
	task automatic idle();
		tx_o.en = 1'b0;
		tx_o.err = ~tx_o.err;
		tx_o.d = ~tx_o.d;
		tx_clk_o = 1'b1;
		#(LINK_PERIOD_NS / 2) tx_clk_o = 1'b0;
		#(LINK_PERIOD_NS / 2);
	endtask
endmodule

`default_nettype wire

/* tb/rgc_mac_if_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module rgc_mac_if_ctrl_bench import rgc_pkg::*; ;
	// ==========================================
	// Signals
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [11:0] reg_addr_i = '0;
	logic [15:0] reg_wdata_i = '0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic [2:0] config_pins_i = '0;
	logic mac_tx_clk_i;
	rgc_nib_t mac_tx_i, core_tx_o;
	rgc_rgrx_t mac_rx_o;
	rgc_crx_t core_rx_i = '0;
	logic irq_o;
	int bad_count = 0;
	int check_count = 0;
	logic [15:0] rq[$];
	rgc_nib_t nq[$];
	logic rd_pend = 1'b0;
	logic pen = 1'b0;
	logic [2:0] ncnt = '0;
	logic [3:0] lastd = '0;
	logic lastc = 1'b0;
	int since = 0;
	int cur = 0;
	int lag = -1;

	rgc_mac_if_ctrl #(.AN_1P6MS_CYC_P(50), .AN_800US_CYC_P(30), .AN_11MS_CYC_P(60)) dut (
		.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .config_pins_i, .mac_tx_clk_i, .mac_tx_i, .mac_rx_o,
		.core_tx_o, .core_rx_i, .irq_o
	);
	rgc_mac_model mac (.tx_clk_o(mac_tx_clk_i), .tx_o(mac_tx_i));

	initial begin
		forever #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
	end

	// ==========================================
	// Compare and report
	task automatic fail(input string m);
		bad_count++;
		$display("mismatch %0t %s", $time, m);
	endtask
	task automatic cmp_reg(input logic [15:0] g, e);
		check_count++;
		if (g !== e) fail($sformatf("read %h expected %h", g, e));
	endtask
	task automatic cmp_nib(input rgc_nib_t g, e);
		check_count++;
		if (g !== e) fail($sformatf("nibble %h expected %h", g, e));
	endtask
	task automatic cmp_rx(input logic [4:0] g, e);
		check_count++;
		if (g !== e) fail($sformatf("receive %h expected %h", g, e));
	endtask
	task automatic cmp_bit(input logic g, e);
		check_count++;
		if (g !== e) fail($sformatf("flag %b expected %b", g, e));
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================
	// Drivers
	task automatic rst(input logic [2:0] p, input int n);
		config_pins_i <= p;
		sys_rst_i <= 1'b1;
		repeat (n) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		rq.push_back(e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic tx_nib(input logic inv, msk, al);
		logic [31:0] r;
		rgc_nib_t n, e;
		r = $urandom();
		n = r[5:0];
		n.en = 1'b1;
		e = n;
		if (inv) e.d = {n.d[0], n.d[1], n.d[2], n.d[3]};
		if (msk) e.err = 1'b0;
		nq.push_back(e);
		mac.send(n, al);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge mclk_i);
		cmp_bit(irq_o, e);
		@(posedge mclk_i);
	endtask
	task automatic chk_rx(input logic [4:0] e);
		@(negedge mclk_i);
		cmp_rx({mac_rx_o.ctl, mac_rx_o.d}, e);
		@(posedge mclk_i);
	endtask

	// ==========================================
	// Result watchers
	always @(posedge mclk_i) rd_pend <= reg_rd_i;
	always @(negedge mclk_i) begin
		if (rd_pend === 1'b1) begin
			if (rq.size() == 0) fail("extra read");
			else cmp_reg(reg_rdata_o, rq.pop_front());
		end
		if (core_tx_o.en === 1'b1) begin
			if (pen !== 1'b1 || ncnt == 3'h7) begin
				if (nq.size() == 0) fail("extra nibble");
				else cmp_nib(core_tx_o, nq.pop_front());
				ncnt <= 3'h0;
			end else begin
				ncnt <= ncnt + 3'h1;
			end
		end
		pen <= core_tx_o.en;
		cur = (mac_rx_o.d !== lastd) ? 0 : since + 1;
		since <= cur;
		if (mac_rx_o.clk === 1'b1 && lastc === 1'b0 && cur < 8) lag <= cur;
		lastd <= mac_rx_o.d;
		lastc <= mac_rx_o.clk;
	end

	initial begin
		#2000000;
		fail("timeout");
		summarize();
	end

	// ==========================================
	// Tests
	initial begin
		logic [2:0] pv;
		logic [31:0] r;
		logic [4:0] x;
		logic [1:0] w;
		int dur[4] = '{50, 40, 30, 60};
		void'($urandom(62));
		for (int p = 0; p < 8; p++) begin
			pv = 3'(p);
			rst(pv, (p == 0) ? 16 : 4);
			rd(OFS_CTRL, {12'h003, pv[2], 3'h0});
			rd(OFS_SKEW, {14'h0, pv[2] & pv[1], pv == 3'h5 || pv == 3'h6});
			rd(OFS_SER, {6'h0, pv == 3'h0, 9'h07B});
			rd(OFS_FIFO, 16'h0000);
			rd(OFS_WAKE, 16'h0000);
			repeat (40) @(posedge mclk_i);
			rd(OFS_IRQ_ST, 16'h0004);
		end
		wr(OFS_CTRL, 16'hFFFF);
		rd(OFS_CTRL, 16'h007F);
		wr(OFS_SKEW, 16'hFFFF);
		rd(OFS_SKEW, 16'h0003);
		wr(OFS_WAKE, 16'hFFFF);
		rd(OFS_WAKE, 16'h0003);
		wr(OFS_FIFO, 16'hFFFF);
		rd(OFS_FIFO, 16'h0000);
		wr(12'h604, 16'hFFFF);
		rd(12'h604, 16'h0000);
		r = $urandom();
		r[0] = 1'b0;
		wr(OFS_SER, r[15:0]);
		rd(OFS_SER, r[15:0]);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_IRQ_ST, 16'h0007);
			wr(OFS_SER, {13'h0, 2'(c), 1'b1});
			repeat (dur[c] - 6) @(posedge mclk_i);
			rd(OFS_IRQ_ST, 16'h0000);
			repeat (8) @(posedge mclk_i);
			rd(OFS_IRQ_ST, 16'h0004);
		end
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CTRL, {9'h0, 3'h4, 1'b1, k[0], 1'b0, k[1]});
			wr(OFS_SKEW, 16'h0001);
			#13;
			for (int j = 0; j < 6; j++) begin
				if (j == 3) cmp_bit(core_tx_o.en, 1'b0);
				tx_nib(k[0], k[1], 1'b1);
			end
			mac.idle();
			repeat (100) @(posedge mclk_i);
			cmp_bit(nq.size() == 0, 1'b1);
		end
		rst(3'h4, 4);
		wr(OFS_CTRL, 16'h0018);
		wr(OFS_IRQ_MSK, 16'h0002);
		chk_irq(1'b0);
		#13;
		repeat (2) tx_nib(1'b0, 1'b0, 1'b0);
		#3000;
		mac.idle();
		@(posedge mclk_i);
		rd(OFS_FIFO, 16'h0001);
		rd(OFS_FIFO, 16'h0000);
		chk_irq(1'b1);
		wr(OFS_IRQ_MSK, 16'h0000);
		chk_irq(1'b0);
		wr(OFS_IRQ_MSK, 16'h0002);
		wr(OFS_IRQ_ST, 16'h0002);
		chk_irq(1'b0);
		for (int i = 0; i < 7; i++) begin
			r = $urandom();
			core_rx_i <= '{lpi: i == 5, lpi_exit: i >= 2 && i <= 4, dv: i < 2,
				err: r[8], d: r[3:0], ib: r[7:4]};
			w = (i == 3) ? 2'b01 : (i == 4) ? 2'b11 : 2'b10;
			wr(OFS_CTRL, {12'h003, i != 0, 1'b0, 1'b1, 1'b0});
			wr(OFS_WAKE, {14'h0, w});
			repeat (12) @(posedge mclk_i);
			case (i)
				0: x = 5'h00;
				1: x = {1'b1, r[0], r[1], r[2], r[3]};
				2: x = {1'b1, r[7:4]};
				3: x = 5'h00;
				4: x = 5'h10;
				5: x = {1'b0, r[7:4]};
				default: x = {r[8], r[7:4]};
			endcase
			chk_rx(x);
		end
		wr(OFS_CTRL, 16'h0038);
		for (int s = 0; s < 2; s++) begin
			wr(OFS_SKEW, {14'h0, 1'(s), 1'b0});
			core_rx_i <= '{dv: 1'b1, d: 4'h5, default: '0};
			repeat (16) @(posedge mclk_i);
			core_rx_i <= '{dv: 1'b1, d: 4'hA, default: '0};
			repeat (16) @(posedge mclk_i);
			cmp_bit(lag == 2 * s, 1'b1);
		end
		cmp_bit(rq.size() == 0 && nq.size() == 0, 1'b1);
		summarize();
	end
endmodule

`default_nettype wire
